//--- verilog/ebcp_top.sv
// board control port: two-wire slave with an 8-bit output latch and conditioner timers
`timescale 1ns/1ps
`default_nettype none

module ebcp_top
   import ebcp_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT, // arbitrary slave address
   parameter logic [TMR_W-1:0] QUIET_CNT = TMR_W'(QUIET_CYCLES), // silence length
   parameter logic [TMR_W-1:0] HIZ_CNT = TMR_W'(HIZ_CYCLES) // high-z length
) (
   input wire logic clk_sys_in, // 25 MHz system clock
   input wire logic rstn_in, // asynchronous reset, active low
   input wire logic scl_in, // two-wire clock pin
   input wire logic sda_in, // two-wire data pin level
   output logic sda_out, // two-wire data drive value
   output logic sda_oe_n_out, // data drive enable, low drives
   input wire logic single_wire_access_in, // one-wire access activity pin
   output ebcp_ctrl_type ctrl_out, // control byte lines
   output logic eeprom_fetch_en_out, // conditioner may fetch eeprom
   output logic serial_bus_quiet_out, // conditioner silent on two-wire
   output logic analog_out_hiz_out // conditioner output high impedance
);

   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;
   logic scl_m_q, scl_s_q, scl_p_q;
   logic sda_m_q, sda_s_q, sda_p_q;
   logic acc_m_q, acc_s_q, acc_p_q;

   // two-stage release of the reset
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // first stages feed only the second stages
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
         acc_m_q <= 1'b0;
         acc_s_q <= 1'b0;
         acc_p_q <= 1'b0;
      end else begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
         acc_m_q <= single_wire_access_in;
         acc_s_q <= acc_m_q;
         acc_p_q <= acc_s_q;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det, access_rise;

   // bus events from the settled copies
   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
   assign access_rise = acc_s_q & ~acc_p_q;

   // ---------------------------------------------------------------
   // two-wire slave and control latch
   // ---------------------------------------------------------------
   ebcp_state_type st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] cnt_q, cnt_d;
   logic rw_q, rw_d;
   ebcp_ctrl_type ctrl_q, ctrl_d;
   logic oe_n_q, oe_n_d;
   logic wr_strobe;

   // protocol next state, shifting and byte latch
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      rw_d = rw_q;
      ctrl_d = ctrl_q;
      wr_strobe = 1'b0;
      if (start_det) begin
         st_d = ST_ADDR;
         cnt_d = 4'h0;
      end else if (stop_det) begin
         st_d = ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               st_d = ST_IDLE;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_s_q};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  rw_d = sh_q[0];
                  st_d = (sh_q[7:1] == BUS_ADDR) ? ST_AACK : ST_WAIT;
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     sh_d = ctrl_q; // read back the latched lines
                     st_d = ST_RDAT;
                  end else begin
                     st_d = ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_s_q};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  wr_strobe = 1'b1;
                  ctrl_d = ebcp_ctrl_type'(sh_q);
                  st_d = ST_DACK;
               end
            end
            ST_DACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  st_d = ST_DATA;
               end
            end
            ST_RDAT: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     st_d = ST_RACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b1};
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise && sda_s_q) begin
                  st_d = ST_WAIT; // master refused more data
               end else if (scl_fall) begin
                  sh_d = ctrl_q;
                  cnt_d = 4'h0;
                  st_d = ST_RDAT;
               end
            end
            ST_WAIT: begin
               st_d = ST_WAIT;
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
      oe_n_d = ~((st_d == ST_AACK) || (st_d == ST_DACK) || ((st_d == ST_RDAT) && !sh_d[7]));
   end

   // protocol registers; the byte holds between writes
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         rw_q <= 1'b0;
         ctrl_q <= CTRL_RESET;
         oe_n_q <= 1'b1;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         rw_q <= rw_d;
         ctrl_q <= ctrl_d;
         oe_n_q <= oe_n_d;
      end
   end

   // ---------------------------------------------------------------
   // conditioner timers and fetch permission
   // ---------------------------------------------------------------
   logic quiet_run, hiz_run, supply_prev_q, supply_applied;
   logic fetch_q, fetch_d;

   // supply applied when the active-low bit drops
   assign supply_applied = supply_prev_q & ~ctrl_q.sensor_supply_off;

   ebcp_timer #(.CYCLES(QUIET_CNT)) u_quiet (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rst_n),
      .restart_in(access_rise),
      .running_out(quiet_run)
   );

   ebcp_timer #(.CYCLES(HIZ_CNT)) u_hiz (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rst_n),
      .restart_in(supply_applied),
      .running_out(hiz_run)
   );

   // fetches only stand-alone, outside the silence and the power-up window
   always_comb begin
      fetch_d = ~ctrl_q.test_pin & ~quiet_run & ~hiz_run;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         fetch_q <= 1'b0;
         supply_prev_q <= 1'b1;
      end else begin
         fetch_q <= fetch_d;
         supply_prev_q <= ctrl_q.sensor_supply_off;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign sda_out = 1'b0; // open drain, only ever pulls low
   assign sda_oe_n_out = oe_n_q;
   assign ctrl_out = ctrl_q;
   assign eeprom_fetch_en_out = fetch_q;
   assign serial_bus_quiet_out = quiet_run;
   assign analog_out_hiz_out = hiz_run;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n);

   sequence s_access_edge;
      access_rise;
   endsequence

   sequence s_supply_on;
      supply_applied;
   endsequence

   a_test_blocks_fetch: assert property (ctrl_q.test_pin |=> !fetch_q)
      else $error("eeprom fetch allowed in test mode");
   a_standalone_fetch: assert property
      (!ctrl_q.test_pin && !quiet_run && !hiz_run |=> fetch_q)
      else $error("eeprom fetch not allowed in stand-alone mode");
   a_quiet_after_access: assert property (s_access_edge |=> quiet_run [*8])
      else $error("two-wire silence not held after one-wire access");
   a_keepalive_holds_fetch: assert property (s_access_edge |-> ##2 !fetch_q [*7])
      else $error("fetch allowed during keep-alive silence");
   a_hiz_after_power: assert property (s_supply_on |=> hiz_run [*8])
      else $error("output not high impedance after power-up");
   a_byte_holds: assert property (!wr_strobe |=> $stable(ctrl_q))
      else $error("control byte changed without a write");
   a_ack_drives_low: assert property (st_q == ST_AACK |-> !oe_n_q)
      else $error("address acknowledge not driven");
   a_wait_released: assert property
      ((st_q == ST_WAIT) || (st_q == ST_IDLE) |-> oe_n_q)
      else $error("data line driven while not addressed");
   a_stop_releases: assert property (stop_det && !start_det |=> st_q == ST_IDLE && oe_n_q)
      else $error("stop did not release the bus");

endmodule

`default_nettype wire

//--- pkg/ebcp_pkg.sv
// shared constants and types of the evaluation board control port
package ebcp_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000; // system clock rate
   localparam int unsigned QUIET_TIME_MS = 1000; // bus silence after a one-wire access
   localparam int unsigned HIZ_TIME_MS = 25; // output high impedance after power-up
   localparam int unsigned QUIET_CYCLES = (CLK_HZ / 1000) * QUIET_TIME_MS;
   localparam int unsigned HIZ_CYCLES = (CLK_HZ / 1000) * HIZ_TIME_MS;
   localparam int unsigned TMR_W = 25; // timer width, holds QUIET_CYCLES

   // ---------------------------------------------------------------
   // two-wire slave
   // ---------------------------------------------------------------
   localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h20; // arbitrary slave address
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ---------------------------------------------------------------
   // control byte layout, bit 7 first
   // ---------------------------------------------------------------
   typedef struct packed {
      logic test_pin; // 7: 1 = conditioner test mode
      logic mode_indicator_drive_n; // 6: active-low indicator
      logic link_indicator_drive_n; // 5: active-low indicator
      logic adc_cal_short; // 4: 1 = adc inputs shorted
      logic spare_out; // 3: free user line
      logic serial_bus_connect; // 2: 1 = sensor two-wire lines joined
      logic sensor_supply_off; // 1: active low supply enable
      logic single_wire_pullup_on; // 0: 1 = pull-up connected
   } ebcp_ctrl_type;

   localparam ebcp_ctrl_type CTRL_RESET = 8'h62; // leds off, supply removed

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_AACK = 3'h3,
      ST_DATA = 3'h2,
      ST_DACK = 3'h6,
      ST_RDAT = 3'h7,
      ST_RACK = 3'h5,
      ST_WAIT = 3'h4
   } ebcp_state_type;

endpackage

//--- verilog/ebcp_timer.sv
// restartable one-shot timer
`timescale 1ns/1ps
`default_nettype none

module ebcp_timer
   import ebcp_pkg::*;
#(
   parameter logic [TMR_W-1:0] CYCLES = 25'h1
) (
   input wire logic clk_sys_in, // system clock
   input wire logic rstn_in, // synchronised reset, active low
   input wire logic restart_in, // one-cycle restart pulse
   output logic running_out // high while the time runs
);

   logic [TMR_W-1:0] cnt_q;
   logic [TMR_W-1:0] cnt_d;
   logic run_q;
   logic run_d;

   // ---------------------------------------------------------------
   // count down, a restart reloads the full time
   // ---------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      if (restart_in) begin
         cnt_d = CYCLES;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
      run_d = (cnt_d != '0);
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end

   assign running_out = run_q;

endmodule

`default_nettype wire

//--- dv/ebcp_host_model.sv
// two-wire bus master standing in for the host software
`timescale 1ns/1ps
`default_nettype none

module ebcp_host_model (
   input wire logic clk_in, // system clock, pacing only
   input wire logic sda_in, // resolved data line
   output logic scl_out, // bus clock from the host
   output logic sda_out // 0 pulls data low, 1 releases
);
   // released lines idle high through the pull-ups
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   // host copies of the two eeprom checksums
   logic [7:0] config_block_checksum = 8'h00;
   logic [7:0] coefficient_block_checksum = 8'h00;

   // one bus phase is five system cycles, above the four-cycle minimum
   task automatic ph();
      repeat (5) @(negedge clk_in);
   endtask

   // data changes only while the clock is low, so no false start or stop
   task automatic bit_io(input logic b, output logic r);
      sda_out = b;
      ph();
      scl_out = 1'b1;
      ph();
      r = sda_in;
      scl_out = 1'b0;
      ph();
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic start_cond();
      sda_out = 1'b1;
      scl_out = 1'b1;
      ph();
      sda_out = 1'b0;
      ph();
      scl_out = 1'b0;
      ph();
   endtask

   task automatic stop_cond();
      sda_out = 1'b0;
      ph();
      scl_out = 1'b1;
      ph();
      sda_out = 1'b1;
      ph();
   endtask

   // whole control byte in one transfer
   task automatic write_byte(input logic [6:0] a, input logic [7:0] d, output logic ack);
      logic a1;
      logic a2;
      start_cond();
      put_byte({a, 1'b0}, a1);
      put_byte(d, a2);
      stop_cond();
      ack = a1 & a2;
      // both checksums redone after every single-byte write; write_two leaves them as they were
      config_block_checksum = 8'hFF - d;
      coefficient_block_checksum = 8'hFF - {a, 1'b0};
   endtask

   // two data bytes in one transfer, each one latches
   task automatic write_two(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1,
                            output logic ack);
      logic a1;
      logic a2;
      logic a3;
      start_cond();
      put_byte({a, 1'b0}, a1);
      put_byte(d0, a2);
      put_byte(d1, a3);
      stop_cond();
      ack = a1 & a2 & a3;
   endtask

   // two bytes read, the first acknowledged by the host, the second refused
   task automatic read_two(input logic [6:0] a, output logic [7:0] d0, output logic [7:0] d1,
                           output logic ack);
      logic r;
      start_cond();
      put_byte({a, 1'b1}, ack);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d0[i]);
      bit_io(1'b0, r);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d1[i]);
      bit_io(1'b1, r);
      stop_cond();
   endtask

   // single byte read ended by a nack
   task automatic read_byte(input logic [6:0] a, output logic [7:0] d, output logic ack);
      logic r;
      start_cond();
      put_byte({a, 1'b1}, ack);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
      stop_cond();
   endtask
endmodule

`default_nettype wire

//--- dv/ebcp_top_tb.sv
// self-checking testbench of the board control port
`timescale 1ns/1ps
`default_nettype none

module ebcp_top_tb;
   import ebcp_pkg::*;
   localparam int QN = 40;
   localparam int HN = 20;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic access = 1'b0;
   logic scl;
   logic sda_m;
   logic dut_sda;
   logic oe_n;
   wire sda_w;
   ebcp_ctrl_type ctrl;
   logic fetch;
   logic quiet;
   logic hiz;
   int mismatches = 0;
   int tests_run = 0;

   // open-drain data line: low when either side pulls
   assign sda_w = sda_m & (oe_n | dut_sda);

   always #20 clk_sys = ~clk_sys;

   ebcp_top #(.QUIET_CNT(TMR_W'(QN)), .HIZ_CNT(TMR_W'(HN))) dut (
      .clk_sys_in(clk_sys), .rstn_in(rstn), .scl_in(scl), .sda_in(sda_w),
      .sda_out(dut_sda), .sda_oe_n_out(oe_n), .single_wire_access_in(access),
      .ctrl_out(ctrl), .eeprom_fetch_en_out(fetch), .serial_bus_quiet_out(quiet),
      .analog_out_hiz_out(hiz));

   ebcp_host_model host (.clk_in(clk_sys), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));

   task automatic stop_test();
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // write one byte, expect both acks and the byte on the lines
   task automatic wr(input logic [7:0] d);
      logic a;
      host.write_byte(BUS_ADDR_DEFAULT, d, a);
      @(negedge clk_sys);
      chk({7'h00, a}, 8'h01);
      chk(ctrl, d);
   endtask

   // wait for a timer output to rise, then count its high cycles
   task automatic count_run(input logic sel, output int n);
      n = 0;
      for (int i = 0; i < 600 && (sel ? hiz : quiet) !== 1'b1; i++) @(negedge clk_sys);
      while ((sel ? hiz : quiet) === 1'b1 && n < 200) begin
         if (n == 3) chk({7'h00, fetch}, 8'h00);
         n++;
         @(negedge clk_sys);
      end
   endtask

   task automatic pulse();
      access = 1'b1;
      repeat (2) @(negedge clk_sys);
      access = 1'b0;
   endtask

   task automatic t_bits();
      logic [7:0] b;
      // each line toggled from the reset byte, alone except lines 2 and 7
      for (int i = 0; i < 8; i++) begin
         b = 8'h62 ^ (8'h01 << i);
         // joining the sensor bus or test mode goes with test high and its indicator lit
         if (i == 2 || i == 7) b = (b | 8'h80) & 8'hBF;
         wr(b);
      end
      wr(8'h62);
   endtask

   task automatic t_read();
      logic [7:0] d;
      logic [7:0] e;
      logic a;
      wr(8'hA7);
      host.read_byte(BUS_ADDR_DEFAULT, d, a);
      chk(d, 8'hA7);
      chk({7'h00, a}, 8'h01);
      host.write_byte(BUS_ADDR_DEFAULT ^ 7'h01, 8'h00, a);
      chk({7'h00, a}, 8'h00);
      chk(ctrl, 8'hA7);
      // host acknowledges the first byte, so the byte is sent again
      host.read_two(BUS_ADDR_DEFAULT, d, e, a);
      chk(d, 8'hA7);
      chk(e, 8'hA7);
      chk({7'h00, a}, 8'h01);
      // every byte of a longer write latches, the last one stays
      host.write_two(BUS_ADDR_DEFAULT, 8'h23, 8'hA6, a);
      @(negedge clk_sys);
      chk({7'h00, a}, 8'h01);
      chk(ctrl, 8'hA6);
   endtask

   task automatic t_mode();
      wr(8'hA2);
      repeat (3) @(negedge clk_sys);
      chk({7'h00, fetch}, 8'h00);
      wr(8'h62);
      repeat (3) @(negedge clk_sys);
      chk({7'h00, fetch}, 8'h01);
   endtask

   // reset in mid-run brings back the reset byte and idle timers
   task automatic t_reset();
      wr(8'hA5);
      rstn = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(ctrl, 8'h62);
      chk({6'h00, fetch, oe_n}, 8'h01);
      rstn = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk({5'h00, oe_n, quiet, hiz}, 8'h04);
      chk({7'h00, fetch}, 8'h01);
   endtask

   task automatic t_timers();
      int n;
      pulse();
      count_run(1'b0, n);
      chk(8'(n), 8'(QN));
      pulse();
      repeat (20) @(negedge clk_sys);
      pulse();
      repeat (QN - 5) @(negedge clk_sys);
      chk({7'h00, quiet}, 8'h01);
      for (int i = 0; i < 20 && quiet !== 1'b0; i++) @(negedge clk_sys);
      repeat (3) @(negedge clk_sys);
      chk({7'h00, fetch}, 8'h01);
      fork
         wr(8'h60);
         count_run(1'b1, n);
      join
      chk(8'(n), 8'(HN));
      wr(8'h62);
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (30000) @(posedge clk_sys);
      mismatches++;
      stop_test();
   end

   initial begin
      repeat (20) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk(ctrl, 8'h62);
      chk({5'h00, oe_n, quiet, hiz}, 8'h04);
      chk({7'h00, fetch}, 8'h01);
      t_bits();
      t_read();
      t_mode();
      t_reset();
      t_timers();
      stop_test();
   end
endmodule

`default_nettype wire
